/* File: verilog/rcf_pkg.sv */
// rcf_pkg: shared constants for the reset-cause flag block
package rcf_pkg;

   // register bus geometry
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int CAUSE_W = 16;

   // register byte offsets
   localparam logic [11:0] OFS_CAUSE = 12'h000;
   localparam logic [11:0] OFS_CTRL = 12'h004;
   localparam logic [11:0] OFS_IRQ_STAT = 12'h008;
   localparam logic [11:0] OFS_IRQ_MASK = 12'h00C;

   // reset_cause_register field positions
   localparam int BIT_TRAP = 15;
   localparam int BIT_ILLOP = 14;
   localparam int BIT_CFGMM = 9;
   localparam int BIT_EXTPIN = 7;
   localparam int BIT_SOFT = 6;
   localparam int BIT_WDT = 4;
   localparam int BIT_SLEEP = 3;
   localparam int BIT_IDLE = 2;
   localparam int BIT_BROWN = 1;
   localparam int BIT_POWERON = 0;

   // control register field positions
   localparam int BIT_WDT_SOFT_EN = 0;

   // reset values and implemented-bit mask
   localparam logic [15:0] CAUSE_RESET = 16'h0003;
   localparam logic [15:0] CAUSE_IMPL = 16'hC2DF;
   localparam logic CTRL_RESET = 1'b0;
   localparam logic [15:0] MASK_RESET = 16'h0000;
   localparam logic [15:0] STAT_RESET = 16'h0000;

   // unprogrammed watchdog configuration value
   localparam logic [1:0] WDT_CFG_UNPROG = 2'h3;

endpackage

/* File: verilog/rcf_irq_bank.sv */
// rcf_irq_bank: sticky interrupt status with write-one-to-clear and mask
module rcf_irq_bank #(
   parameter int WIDTH = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // events and software access
   input wire logic [WIDTH-1:0] set_vec,
   input wire logic clr_we,
   input wire logic [WIDTH-1:0] clr_vec,
   input wire logic mask_we,
   input wire logic [WIDTH-1:0] mask_wdata,
   // state and interrupt
   output logic [WIDTH-1:0] status_q,
   output logic [WIDTH-1:0] mask_q,
   output logic irq
);

   // sticky status: a new event in the clearing cycle survives the clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status_q <= rcf_pkg::STAT_RESET;
      end else if (clk_en) begin
         if (clr_we) begin
            status_q <= (status_q & ~clr_vec) | set_vec;
         end else begin
            status_q <= status_q | set_vec;
         end
      end
   end

   // mask register, one enable per status bit
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mask_q <= rcf_pkg::MASK_RESET;
      end else if (clk_en && mask_we) begin
         mask_q <= mask_wdata;
      end
   end

   // level interrupt while any enabled status bit is set
   assign irq = |(status_q & mask_q);

endmodule

/* File: verilog/rcf_reset_cause.sv */
// rcf_reset_cause: reset-cause flag register with APB slave and interrupt
//
// Functional notes
// - trap conflict sets bit 15, POR/software clear
// - illegal opcode/uninit W sets bit 14
// - configuration mismatch sets bit 9
// - master clear pin reset sets bit 7
// - reset instruction sets bit 6
// - watchdog expiry sets bit 4; power-save clears
// - sleep entry sets bit 3
// - idle entry sets bit 2
// - brown-out and POR set bit 1
// - POR sets bit 0; only software clears
// - software writes any flag, never resets
// - config field 11 forces watchdog running
//
// The implementer's own choices: the APB register port and the address map.
module rcf_reset_cause #(
   parameter int ADDR_W = rcf_pkg::ADDR_W
) (
   // clock, power-on reset, clock enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // reset and wake events, one-cycle pulses
   input wire logic trap_conflict_evt,
   input wire logic illegal_op_evt,
   input wire logic config_mismatch_evt,
   input wire logic master_clear_pin_evt,
   input wire logic soft_reset_evt,
   input wire logic watchdog_expire_evt,
   input wire logic power_save_instruction,
   input wire logic sleep_entry_evt,
   input wire logic idle_entry_evt,
   input wire logic brownout_evt,
   // watchdog enable
   input wire logic [1:0] watchdog_config_field,
   output logic watchdog_run,
   // flags and interrupt
   output logic [15:0] reset_cause_register,
   output logic irq
);

   logic [15:0] cause_q;
   logic [15:0] cause_d;
   logic [15:0] set_vec;
   logic ctrl_q;
   logic rvalid_q;
   logic [31:0] rdata_d;
   logic [15:0] irq_stat;
   logic [15:0] irq_mask;
   logic xfer;
   logic wr_xfer;
   logic wr_cause;
   logic wr_ctrl;
   logic wr_stat;
   logic wr_mask;
   logic hit_any;
   logic [15:0] wdata16;

   // address match on the word offset; used by decode and read mux
   function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                     input logic [11:0] ofs);
      addr_hit = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
   endfunction

   // apb handshake: writes finish at once, reads wait for captured data
   assign hit_any = addr_hit(paddr, rcf_pkg::OFS_CAUSE) ||
                    addr_hit(paddr, rcf_pkg::OFS_CTRL) ||
                    addr_hit(paddr, rcf_pkg::OFS_IRQ_STAT) ||
                    addr_hit(paddr, rcf_pkg::OFS_IRQ_MASK);
   assign pready = clk_en && (pwrite || rvalid_q);
   assign pslverr = psel && penable && pready && !hit_any;
   assign xfer = psel && penable && pready;
   assign wr_xfer = xfer && pwrite && hit_any;

   // lower two byte lanes carry the 16-bit registers; others are ignored
   assign wdata16 = {pstrb[1] ? pwdata[15:8] : 8'h00,
                     pstrb[0] ? pwdata[7:0] : 8'h00};
   assign wr_cause = wr_xfer && addr_hit(paddr, rcf_pkg::OFS_CAUSE);
   assign wr_ctrl = wr_xfer && addr_hit(paddr, rcf_pkg::OFS_CTRL);
   assign wr_stat = wr_xfer && addr_hit(paddr, rcf_pkg::OFS_IRQ_STAT);
   assign wr_mask = wr_xfer && addr_hit(paddr, rcf_pkg::OFS_IRQ_MASK);

   // hardware set events gathered into the flag layout
   always_comb begin
      set_vec = 16'h0000;
      set_vec[rcf_pkg::BIT_TRAP] = trap_conflict_evt;
      set_vec[rcf_pkg::BIT_ILLOP] = illegal_op_evt;
      set_vec[rcf_pkg::BIT_CFGMM] = config_mismatch_evt;
      set_vec[rcf_pkg::BIT_EXTPIN] = master_clear_pin_evt;
      set_vec[rcf_pkg::BIT_SOFT] = soft_reset_evt;
      set_vec[rcf_pkg::BIT_WDT] = watchdog_expire_evt;
      set_vec[rcf_pkg::BIT_SLEEP] = sleep_entry_evt;
      set_vec[rcf_pkg::BIT_IDLE] = idle_entry_evt;
      set_vec[rcf_pkg::BIT_BROWN] = brownout_evt;
   end

   // next flag value: write, then power-save clear, then set wins over both
   always_comb begin
      cause_d = cause_q;
      if (wr_cause) begin
         cause_d = wdata16 & rcf_pkg::CAUSE_IMPL;
      end
      if (power_save_instruction) begin
         cause_d[rcf_pkg::BIT_WDT] = 1'b0;
      end
      cause_d = cause_d | set_vec;
   end

   // flags: only the power-on reset (presetn) returns them to reset value;
   // other resets arrive as events and never clear anything
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cause_q <= rcf_pkg::CAUSE_RESET;
      end else if (clk_en) begin
         cause_q <= cause_d;
      end
   end
   assign reset_cause_register = cause_q;

   // software watchdog enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= rcf_pkg::CTRL_RESET;
      end else if (clk_en && wr_ctrl) begin
         ctrl_q <= wdata16[rcf_pkg::BIT_WDT_SOFT_EN];
      end
   end

   // unprogrammed configuration overrides the software bit
   assign watchdog_run = (watchdog_config_field == rcf_pkg::WDT_CFG_UNPROG)
                         || ctrl_q;

   // read mux; unmapped offsets read as zero
   always_comb begin
      rdata_d = 32'h00000000;
      if (addr_hit(paddr, rcf_pkg::OFS_CAUSE)) begin
         rdata_d = {16'h0000, cause_q};
      end else if (addr_hit(paddr, rcf_pkg::OFS_CTRL)) begin
         rdata_d = {31'h00000000, ctrl_q};
      end else if (addr_hit(paddr, rcf_pkg::OFS_IRQ_STAT)) begin
         rdata_d = {16'h0000, irq_stat};
      end else if (addr_hit(paddr, rcf_pkg::OFS_IRQ_MASK)) begin
         rdata_d = {16'h0000, irq_mask};
      end
   end

   // read data captured once per transfer, so prdata comes from a flop;
   // costs one cycle when the setup cycle saw the clock enable low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rvalid_q <= 1'b0;
         prdata <= 32'h00000000;
      end else if (clk_en) begin
         if (xfer) begin
            rvalid_q <= 1'b0;
         end else if (psel && !pwrite && !rvalid_q) begin
            rvalid_q <= 1'b1;
            prdata <= rdata_d;
         end
      end
   end

   // interrupt status mirrors each hardware flag event
   rcf_irq_bank #(
      .WIDTH(16)
   ) u_irq (
      .clk(pclk),
      .rst_n(presetn),
      .clk_en(clk_en),
      .set_vec(set_vec),
      .clr_we(wr_stat),
      .clr_vec(wdata16),
      .mask_we(wr_mask),
      .mask_wdata(wdata16 & rcf_pkg::CAUSE_IMPL),
      .status_q(irq_stat),
      .mask_q(irq_mask),
      .irq(irq)
   );

   // checks on the flag and bus behaviour
   sequence s_cause_write;
      clk_en && psel && penable && pready && pwrite &&
      addr_hit(paddr, rcf_pkg::OFS_CAUSE);
   endsequence

   sequence s_quiet;
      set_vec == 16'h0000 && !power_save_instruction;
   endsequence

   property p_trap_set;
      @(posedge pclk) disable iff (!presetn)
      clk_en && trap_conflict_evt |=> cause_q[rcf_pkg::BIT_TRAP];
   endproperty
   a_trap_set: assert property (p_trap_set)
      else $error("trap flag not set");

   property p_illop_set;
      @(posedge pclk) disable iff (!presetn)
      clk_en && illegal_op_evt |=> reset_cause_register[14];
   endproperty
   a_illop_set: assert property (p_illop_set)
      else $error("illegal op flag not set");

   property p_cfgmm_set;
      @(posedge pclk) disable iff (!presetn)
      clk_en && config_mismatch_evt |=> reset_cause_register[9];
   endproperty
   a_cfgmm_set: assert property (p_cfgmm_set)
      else $error("config mismatch flag not set");

   property p_extpin_set;
      @(posedge pclk) disable iff (!presetn)
      clk_en && master_clear_pin_evt |=> reset_cause_register[7];
   endproperty
   a_extpin_set: assert property (p_extpin_set)
      else $error("external pin flag not set");

   property p_soft_set;
      @(posedge pclk) disable iff (!presetn)
      clk_en && soft_reset_evt |=> reset_cause_register[6];
   endproperty
   a_soft_set: assert property (p_soft_set)
      else $error("soft reset flag not set");

   property p_wdt_clear;
      @(posedge pclk) disable iff (!presetn)
      clk_en && power_save_instruction && !watchdog_expire_evt &&
      !wr_cause |=> !reset_cause_register[4];
   endproperty
   a_wdt_clear: assert property (p_wdt_clear)
      else $error("watchdog flag not cleared by power save");

   property p_wdt_set;
      @(posedge pclk) disable iff (!presetn)
      clk_en && watchdog_expire_evt |=> reset_cause_register[4];
   endproperty
   a_wdt_set: assert property (p_wdt_set)
      else $error("watchdog flag lost");

   property p_sleep_set;
      @(posedge pclk) disable iff (!presetn)
      clk_en && sleep_entry_evt |=> reset_cause_register[3];
   endproperty
   a_sleep_set: assert property (p_sleep_set)
      else $error("sleep flag not set");

   property p_idle_set;
      @(posedge pclk) disable iff (!presetn)
      clk_en && idle_entry_evt |=> reset_cause_register[2];
   endproperty
   a_idle_set: assert property (p_idle_set)
      else $error("idle flag not set");

   property p_brown_set;
      @(posedge pclk) disable iff (!presetn)
      clk_en && brownout_evt |=> reset_cause_register[1];
   endproperty
   a_brown_set: assert property (p_brown_set)
      else $error("brown-out flag not set");

   property p_poweron_hold;
      @(posedge pclk) disable iff (!presetn)
      reset_cause_register[0] && !wr_cause
      |=> reset_cause_register[0];
   endproperty
   a_poweron_hold: assert property (p_poweron_hold)
      else $error("power-on flag cleared by hardware");

   property p_sw_write;
      @(posedge pclk) disable iff (!presetn)
      s_cause_write and s_quiet
      |=> reset_cause_register == $past(wdata16 & rcf_pkg::CAUSE_IMPL);
   endproperty
   a_sw_write: assert property (p_sw_write)
      else $error("software write not stored");

   property p_wdt_forced;
      @(posedge pclk) disable iff (!presetn)
      watchdog_config_field == 2'h3 |-> watchdog_run;
   endproperty
   a_wdt_forced: assert property (p_wdt_forced)
      else $error("watchdog not forced on");

   property p_flags_persist;
      @(posedge pclk) disable iff (!presetn)
      !wr_cause && !power_save_instruction
      |=> (reset_cause_register & $past(reset_cause_register)) ==
          $past(reset_cause_register);
   endproperty
   a_flags_persist: assert property (p_flags_persist)
      else $error("flag dropped without software or power-on reset");

   property p_irq_follow;
      @(posedge pclk) disable iff (!presetn)
      clk_en && trap_conflict_evt ##1 irq_mask[15] |-> irq;
   endproperty
   a_irq_follow: assert property (p_irq_follow)
      else $error("unmasked event gave no interrupt");

   // a low clock enable must hold the flags, interrupt status, mask and control bit, events included
   property p_freeze;
      @(posedge pclk) disable iff (!presetn)
      !clk_en |=> $stable({reset_cause_register, irq_stat,
                           irq_mask, ctrl_q});
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("state moved while the clock enable was low");

   // read: setup with the clock enabled, then a zero-wait access phase
   sequence s_read_setup;
      clk_en && psel && !penable && !pwrite;
   endsequence

   sequence s_read_access;
      clk_en && psel && penable && !pwrite;
   endsequence

   property p_read_ready;
      @(posedge pclk) disable iff (!presetn)
      s_read_setup ##1 s_read_access |-> pready;
   endproperty
   a_read_ready: assert property (p_read_ready)
      else $error("read not answered in the first access cycle");

   // registers are 16 bits wide, so the upper half must read as zero
   property p_read_upper;
      @(posedge pclk) disable iff (!presetn)
      psel && penable && pready && !pwrite |-> prdata[31:16] == 16'h0000;
   endproperty
   a_read_upper: assert property (p_read_upper)
      else $error("upper read half not zero");

   property p_unmapped_read;
      @(posedge pclk) disable iff (!presetn)
      psel && penable && pready && !pwrite && !hit_any |-> prdata == 32'h0;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read)
      else $error("unmapped read returned data");

   // interrupt status only drops through a software clear
   property p_stat_sticky;
      @(posedge pclk) disable iff (!presetn)
      !wr_stat |=> (irq_stat & $past(irq_stat)) == $past(irq_stat);
   endproperty
   a_stat_sticky: assert property (p_stat_sticky)
      else $error("interrupt status dropped without a clear");

endmodule

/* File: bench/rcf_reset_cause_tb.sv */
// rcf_reset_cause_tb: self-checking bench for the reset-cause flag block
module rcf_reset_cause_tb;
   timeunit 1ns;
   timeprecision 100ps;

   // clock, reset and bus
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic clk_en = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] pstrb = 4'hF;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   // events: index 9 is the power-save clear, the rest are causes
   logic [9:0] ev = 10'h000;
   logic [1:0] cfg = 2'h0;
   logic watchdog_run;
   logic [15:0] cause;
   logic irq;
   // bookkeeping
   int err_total = 0;
   int checked = 0;
   int seed = 97;
   logic [32:0] notes[$];
   logic [32:0] note;
   logic [31:0] rv;
   int ebit[9] = '{15, 14, 9, 7, 6, 4, 3, 2, 1};

   // free-running bus clock, 8 ns period
   always #4 pclk = ~pclk;

   rcf_reset_cause i_dut (
      .pclk(pclk), .presetn(presetn), .clk_en(clk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr),
      .trap_conflict_evt(ev[0]), .illegal_op_evt(ev[1]),
      .config_mismatch_evt(ev[2]), .master_clear_pin_evt(ev[3]),
      .soft_reset_evt(ev[4]), .watchdog_expire_evt(ev[5]),
      .power_save_instruction(ev[9]), .sleep_entry_evt(ev[6]),
      .idle_entry_evt(ev[7]), .brownout_evt(ev[8]),
      .watchdog_config_field(cfg), .watchdog_run(watchdog_run),
      .reset_cause_register(cause), .irq(irq)
   );

   task check(input string name, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task conclude;
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // one apb transfer; pready is sampled at the rising edge it qualifies,
   // and the request is released only after that edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      check("pready", {31'h0, pready}, 32'h1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   // the note holds {pslverr, prdata} expected for the read
   task rd(input logic [11:0] a, input logic [32:0] e);
      notes.push_back(e);
      apb(1'b0, a, 32'h0000_0000);
   endtask

   task pulse(input int k);
      @(posedge pclk);
      ev <= 10'h001 << k;
      @(posedge pclk);
      ev <= 10'h000;
   endtask

   // level output compared mid-cycle, after it has settled
   task pin(input string name, input logic exp);
      logic seen;
      @(negedge pclk);
      seen = (name == "irq") ? irq : watchdog_run;
      check(name, {31'h0, seen}, {31'h0, exp});
   endtask

   // read monitor: each completing read takes the oldest note
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && pwrite === 1'b0) begin
         note = notes.pop_front();
         check("prdata", prdata, note[31:0]);
         check("pslverr", {31'h0, pslverr}, {31'h0, note[32]});
      end
   end

   // watchdog: a hang counts as a mismatch
   initial begin
      #200000;
      err_total++;
      conclude;
   end

   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      check("cause", {16'h0, cause}, 32'h0000_0003);
      rd(rcf_pkg::OFS_CAUSE, 33'h3);
      rd(rcf_pkg::OFS_CTRL, 33'h0);
      rd(rcf_pkg::OFS_IRQ_MASK, 33'h0);
      // unmapped place: refused, write has no effect
      rd(12'h010, 33'h1_0000_0000);
      wr(12'h010, 32'hFFFF_FFFF);
      rd(rcf_pkg::OFS_CAUSE, 33'h3);
      // every cause in turn, with its interrupt status bit
      for (int i = 0; i < 9; i++) begin
         wr(rcf_pkg::OFS_CAUSE, 32'h0);
         pulse(i);
         rd(rcf_pkg::OFS_CAUSE, 33'h1 << ebit[i]);
         rd(rcf_pkg::OFS_IRQ_STAT, 33'h1 << ebit[i]);
         wr(rcf_pkg::OFS_IRQ_STAT, 32'h1 << ebit[i]);
      end
      // power-save clears only the watchdog flag
      wr(rcf_pkg::OFS_CAUSE, 32'h0000_C2DF);
      pulse(9);
      rd(rcf_pkg::OFS_CAUSE, 33'hC2CF);
      // non-power-on resets leave every flag standing
      wr(rcf_pkg::OFS_CAUSE, 32'h0000_C2DF);
      pulse(3);
      pulse(4);
      pulse(5);
      rd(rcf_pkg::OFS_CAUSE, 33'hC2DF);
      // software sets and clears any flag; unimplemented bits read zero
      for (int i = 0; i < 6; i++) begin
         rv = $random(seed);
         wr(rcf_pkg::OFS_CAUSE, rv);
         rd(rcf_pkg::OFS_CAUSE, {17'h0, rv[15:0] & 16'hC2DF});
      end
      // interrupt raised, masked, unmasked and cleared
      wr(rcf_pkg::OFS_IRQ_STAT, 32'h0000_FFFF);
      wr(rcf_pkg::OFS_IRQ_MASK, 32'h0000_FFFF);
      pulse(0);
      pin("irq", 1'b1);
      wr(rcf_pkg::OFS_IRQ_MASK, 32'h0000_7FFF);
      pin("irq", 1'b0);
      wr(rcf_pkg::OFS_IRQ_MASK, 32'h0000_8000);
      pin("irq", 1'b1);
      wr(rcf_pkg::OFS_IRQ_STAT, 32'h0000_8000);
      pin("irq", 1'b0);
      rd(rcf_pkg::OFS_IRQ_STAT, 33'h0);
      // clock enable low freezes the flags: an event then is not taken
      wr(rcf_pkg::OFS_CAUSE, 32'h0);
      clk_en <= 1'b0;
      pulse(0);
      @(posedge pclk);
      clk_en <= 1'b1;
      rd(rcf_pkg::OFS_CAUSE, 33'h0);
      rd(rcf_pkg::OFS_IRQ_STAT, 33'h0);
      // watchdog running: forced by the unprogrammed field
      for (int c = 0; c < 4; c++) begin
         for (int s = 0; s < 2; s++) begin
            wr(rcf_pkg::OFS_CTRL, 32'(s));
            @(posedge pclk);
            cfg <= 2'(c);
            pin("watchdog_run", c == 3 || s == 1);
         end
      end
      // a second power-on reset in mid-run
      wr(rcf_pkg::OFS_CAUSE, 32'h0000_C2DC);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(rcf_pkg::OFS_CAUSE, 33'h3);
      rd(rcf_pkg::OFS_IRQ_MASK, 33'h0);
      repeat (2) @(posedge pclk);
      conclude;
   end
endmodule
